// ### logic/sce_word_bank.sv
/*
 * Nonvolatile configuration and coefficient word bank with its power-up
 * loader, write lock, signature writer and derived working outputs.
 * Assumes the two-wire front end decodes frames into word commands and
 * that reset marks a power cycle; the memory array itself keeps its
 * contents through reset.
 */
`timescale 1ns/1ps

module sce_word_bank
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Word commands from the two-wire front end
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [sce_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [sce_pkg::WORD_W-1:0] cmd_wdata,
	input wire logic enter_normal_operation_cmd,
	output logic rsp_valid,
	output logic [sce_pkg::WORD_W-1:0] rsp_rdata,
	output logic write_refused,
	// Address filter for incoming frames
	input wire logic [6:0] bus_addr,
	output logic addr_accept,
	// Working configuration
	output sce_pkg::sce_cfg_t cfg,
	output logic charge_pump_en,
	output logic diag_state,
	// Working coefficients
	output sce_pkg::sce_coef_t coef
);

	sce_pkg::sce_regs_t r_r;
	sce_pkg::sce_regs_t r_nxt;
	// Factory image; the array keeps it through reset, which stands for a power cycle
	logic [15:0] nv_mem [0:sce_pkg::WORDS-1] = '{
		sce_pkg::OFS_IF_CFG: sce_pkg::IF_CFG_DEFAULT,
		sce_pkg::OFS_BRIDGE_GAIN: sce_pkg::UNITY_GAIN,
		sce_pkg::OFS_TEMP_GAIN: sce_pkg::UNITY_GAIN,
		sce_pkg::OFS_SIGNATURE: 16'(sce_pkg::IF_CFG_DEFAULT + sce_pkg::UNITY_GAIN + sce_pkg::UNITY_GAIN),
		default: sce_pkg::WORD_ZERO
	};
	logic [31:0][15:0] nv_view;
	logic nv_we;
	logic [4:0] nv_waddr;
	logic [15:0] nv_wdata;
	logic cmd_take;

	function automatic logic [15:0] sum_words(input logic [31:0][15:0] w);
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < 31; i++)
		begin
			s = s + w[i];
		end
		return s;
	endfunction

	function automatic logic signed [16:0] signed_mag(input logic [15:0] mag, input logic neg);
		logic signed [16:0] v;
		v = $signed({1'b0, mag});
		return neg ? -v : v;
	endfunction

	function automatic logic [17:0] times_eight(input logic [15:0] w);
		logic [14:0] mag;
		mag = w[14:0];
		return w[sce_pkg::GAIN_X8_BIT] ? {mag, 3'h0} : {3'h0, mag};
	endfunction

	function automatic logic addr_match(input logic [6:0] a, input logic [6:0] own, input logic locked);
		return !locked || (a == own);
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < sce_pkg::WORDS; gi++)
		begin : g_view
			assign nv_view[gi] = nv_mem[gi];
		end
	endgenerate

	// No reset: contents survive a power cycle
	always_ff @(posedge mclk)
	begin
		if (nv_we)
		begin
			nv_mem[nv_waddr] <= nv_wdata;
		end
	end

	// Signature request blocks the command path for that cycle
	assign cmd_ready = (r_r.state == sce_pkg::SCE_RUN) && !enter_normal_operation_cmd;
	assign cmd_take = cmd_valid && cmd_ready;
	assign addr_accept = (r_r.state == sce_pkg::SCE_RUN)
		&& addr_match(bus_addr, r_r.cfg.slave_addr, r_r.cfg.comm_locked);

	always_comb
	begin
		r_nxt = r_r;
		r_nxt.rsp_valid = 1'b0;
		r_nxt.write_refused = 1'b0;
		nv_we = 1'b0;
		nv_waddr = cmd_addr;
		nv_wdata = cmd_wdata;
		case (r_r.state)
			sce_pkg::SCE_LOAD:
			begin
				r_nxt.work[r_r.idx] = nv_view[r_r.idx];
				r_nxt.idx = r_r.idx + 5'h01;
				if (r_r.idx == sce_pkg::OFS_LAST)
				begin
					r_nxt.state = sce_pkg::SCE_DERIVE;
				end
			end
			sce_pkg::SCE_DERIVE:
			begin
				// Interface word is read only here, so edits wait for a power cycle
				r_nxt.cfg.miso_on_rising = r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_EDGE_BIT];
				r_nxt.cfg.conn_check_en = r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_CONN_CHK_BIT];
				r_nxt.cfg.short_check_en = r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_SHORT_CHK_BIT];
				r_nxt.cfg.slave_addr = r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_ADDR_LSB +: 7];
				r_nxt.cfg.comm_locked = r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_COMM_LOCK_LSB +: 3]
					== sce_pkg::LOCK_CODE;
				r_nxt.cfg.mem_locked = r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_MEM_LOCK_LSB +: 3]
					== sce_pkg::LOCK_CODE;
				r_nxt.cfg.curve_shape_select = r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_CURVE_BIT];
				r_nxt.coef.bridge_offset = $signed(r_r.work[sce_pkg::OFS_BRIDGE_OFFSET]);
				r_nxt.coef.bridge_gain = times_eight(r_r.work[sce_pkg::OFS_BRIDGE_GAIN]);
				r_nxt.coef.gain_tc = signed_mag(r_r.work[sce_pkg::OFS_GAIN_TC],
					r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_TC_GAIN_BIT]);
				r_nxt.coef.offset_tc = signed_mag(r_r.work[sce_pkg::OFS_OFFSET_TC],
					r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_TC_OFFSET_BIT]);
				r_nxt.coef.offset_sot = signed_mag(r_r.work[sce_pkg::OFS_OFFSET_SOT],
					r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_SOT_OFFSET_BIT]);
				r_nxt.coef.gain_sot = signed_mag(r_r.work[sce_pkg::OFS_GAIN_SOT],
					r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_SOT_GAIN_BIT]);
				r_nxt.coef.bridge_sot = signed_mag(r_r.work[sce_pkg::OFS_BRIDGE_SOT],
					r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_BRIDGE_SECOND_ORDER_BIT]);
				r_nxt.coef.temp_offset = r_r.work[sce_pkg::OFS_TEMP_OFFSET];
				r_nxt.coef.temp_gain = times_eight(r_r.work[sce_pkg::OFS_TEMP_GAIN]);
				r_nxt.coef.temp_sot = signed_mag(r_r.work[sce_pkg::OFS_TEMP_SOT],
					r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_SOT_TEMP_BIT]);
				r_nxt.coef.low_cal_raw_temperature = r_r.work[sce_pkg::OFS_LOW_CAL_TEMP];
				r_nxt.coef.customer_id = {r_r.work[sce_pkg::OFS_CUST_ID2], r_r.work[sce_pkg::OFS_CUSTOMER_IDENTIFIER_WORD_ONE],
					r_r.work[sce_pkg::OFS_CUST_ID0]};
				// Only a locked part checks, since unlocked parts may be mid-calibration
				r_nxt.diag_state = (r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_MEM_LOCK_LSB +: 3] == sce_pkg::LOCK_CODE)
					&& (sum_words(r_r.work) != r_r.work[sce_pkg::OFS_SIGNATURE]);
				r_nxt.state = sce_pkg::SCE_RUN;
			end
			sce_pkg::SCE_RUN:
			begin
				if (enter_normal_operation_cmd && !r_r.cfg.mem_locked)
				begin
					// Pending lock is not yet effective, so the signature still lands
					nv_we = 1'b1;
					nv_waddr = sce_pkg::OFS_SIGNATURE;
					nv_wdata = sum_words(nv_view);
				end
				else if (cmd_take && cmd_write)
				begin
					nv_we = !r_r.cfg.mem_locked;
					r_nxt.write_refused = r_r.cfg.mem_locked;
				end
				else if (cmd_take)
				begin
					r_nxt.rsp_valid = 1'b1;
					r_nxt.rsp_rdata = nv_view[cmd_addr];
				end
			end
			default:
			begin
				r_nxt.state = sce_pkg::SCE_LOAD;
				r_nxt.idx = 5'h00;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			r_r <= '0;
			r_r.state <= sce_pkg::SCE_LOAD;
		end
		else
		begin
			r_r <= r_nxt;
		end
	end

	assign rsp_valid = r_r.rsp_valid;
	assign rsp_rdata = r_r.rsp_rdata;
	assign write_refused = r_r.write_refused;
	assign cfg = r_r.cfg;
	assign coef = r_r.coef;
	assign diag_state = r_r.diag_state;
	assign charge_pump_en = (r_r.state == sce_pkg::SCE_RUN) && !r_r.cfg.mem_locked;

	property p_no_answer_in_load;
		@(posedge mclk) disable iff (reset)
		(r_r.state != sce_pkg::SCE_RUN) |-> !cmd_ready && !rsp_valid && !addr_accept;
	endproperty
	a_no_answer_in_load: assert property (p_no_answer_in_load) else $error("bank answered before load");

	property p_locked_write_refused;
		@(posedge mclk) disable iff (reset)
		(cmd_take && cmd_write && cfg.mem_locked) |=> write_refused && !rsp_valid;
	endproperty
	a_locked_write_refused: assert property (p_locked_write_refused) else $error("locked write not refused");

	property p_pump_off_locked;
		@(posedge mclk) disable iff (reset)
		cfg.mem_locked |-> !charge_pump_en && !nv_we;
	endproperty
	a_pump_off_locked: assert property (p_pump_off_locked) else $error("pump or write active while locked");

	property p_addr_filter;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) |-> addr_accept == (!cfg.comm_locked || bus_addr == cfg.slave_addr);
	endproperty
	a_addr_filter: assert property (p_addr_filter) else $error("address filter wrong");

	property p_cfg_stable_in_run;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) ##1 (r_r.state == sce_pkg::SCE_RUN) |-> $stable(cfg);
	endproperty
	a_cfg_stable_in_run: assert property (p_cfg_stable_in_run) else $error("configuration changed without power cycle");

	property p_edge_from_word;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_DERIVE) |=> cfg.miso_on_rising == $past(r_r.work[sce_pkg::OFS_IF_CFG][0]);
	endproperty
	a_edge_from_word: assert property (p_edge_from_word) else $error("edge select not taken from word");

	property p_gain_times_eight;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) |-> coef.bridge_gain == (r_r.work[sce_pkg::OFS_BRIDGE_GAIN][15]
			? 18'(r_r.work[sce_pkg::OFS_BRIDGE_GAIN][14:0]) * 18'h00008 : 18'(r_r.work[sce_pkg::OFS_BRIDGE_GAIN][14:0]));
	endproperty
	a_gain_times_eight: assert property (p_gain_times_eight) else $error("bridge gain factor wrong");

	property p_offset_first_order_sign_field;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) && (r_r.work[sce_pkg::OFS_OFFSET_TC] != 16'h0000)
			|-> coef.offset_tc[16] == r_r.work[sce_pkg::OFS_SIGN_CFG][10];
	endproperty
	a_offset_first_order_sign_field: assert property (p_offset_first_order_sign_field) else $error("offset drift sign wrong");

	property p_diag_on_bad_signature;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) && cfg.mem_locked
			|-> diag_state == (sum_words(r_r.work) != r_r.work[sce_pkg::OFS_SIGNATURE]);
	endproperty
	a_diag_on_bad_signature: assert property (p_diag_on_bad_signature) else $error("diagnostic state wrong");

	property p_load_length;
		@(posedge mclk) disable iff (reset)
		$rose(r_r.state == sce_pkg::SCE_DERIVE) |-> $past(r_r.idx) == 5'h1F ##1 r_r.state == sce_pkg::SCE_RUN;
	endproperty
	a_load_length: assert property (p_load_length) else $error("load walk length wrong");

	property p_read_answer;
		@(posedge mclk) disable iff (reset)
		(cmd_take && !cmd_write) |=> rsp_valid && (rsp_rdata == $past(nv_view[cmd_addr]));
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer wrong");

	property p_write_lands;
		@(posedge mclk) disable iff (reset)
		(cmd_take && cmd_write && !cfg.mem_locked) |=> nv_view[$past(cmd_addr)] == $past(cmd_wdata);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("unlocked write lost");

	property p_signature_write;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) && enter_normal_operation_cmd && !cfg.mem_locked
			|=> nv_view[sce_pkg::OFS_SIGNATURE] == $past(sum_words(nv_view));
	endproperty
	a_signature_write: assert property (p_signature_write) else $error("signature not written");

	property p_diag_enables;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_DERIVE)
			|=> cfg.conn_check_en == $past(r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_CONN_CHK_BIT])
			&& cfg.short_check_en == $past(r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_SHORT_CHK_BIT]);
	endproperty
	a_diag_enables: assert property (p_diag_enables) else $error("diagnostic enables wrong");

	property p_slave_addr;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_DERIVE)
			|=> cfg.slave_addr == $past(r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_ADDR_LSB +: 7]);
	endproperty
	a_slave_addr: assert property (p_slave_addr) else $error("slave address wrong");

	property p_comm_lock_decode;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_DERIVE)
			|=> cfg.comm_locked
			== ($past(r_r.work[sce_pkg::OFS_IF_CFG][sce_pkg::IF_COMM_LOCK_LSB +: 3]) == sce_pkg::LOCK_CODE);
	endproperty
	a_comm_lock_decode: assert property (p_comm_lock_decode) else $error("address lock decode wrong");

	property p_bridge_offset;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) |-> coef.bridge_offset == $signed(r_r.work[sce_pkg::OFS_BRIDGE_OFFSET]);
	endproperty
	a_bridge_offset: assert property (p_bridge_offset) else $error("bridge offset wrong");

	property p_temp_gain;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) |-> coef.temp_gain == (r_r.work[sce_pkg::OFS_TEMP_GAIN][15]
			? 18'(r_r.work[sce_pkg::OFS_TEMP_GAIN][14:0]) * 18'h00008 : 18'(r_r.work[sce_pkg::OFS_TEMP_GAIN][14:0]));
	endproperty
	a_temp_gain: assert property (p_temp_gain) else $error("temperature gain factor wrong");

	property p_gain_first_order_sign_field;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) && (r_r.work[sce_pkg::OFS_GAIN_TC] != 16'h0000)
			|-> coef.gain_tc[16] == r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_TC_GAIN_BIT];
	endproperty
	a_gain_first_order_sign_field: assert property (p_gain_first_order_sign_field) else $error("gain drift sign wrong");

	property p_offset_second_order_sign_field;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) && (r_r.work[sce_pkg::OFS_OFFSET_SOT] != 16'h0000)
			|-> coef.offset_sot[16] == r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_SOT_OFFSET_BIT];
	endproperty
	a_offset_second_order_sign_field: assert property (p_offset_second_order_sign_field) else $error("offset second order sign wrong");

	property p_gain_second_order_sign_field;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) && (r_r.work[sce_pkg::OFS_GAIN_SOT] != 16'h0000)
			|-> coef.gain_sot[16] == r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_SOT_GAIN_BIT];
	endproperty
	a_gain_second_order_sign_field: assert property (p_gain_second_order_sign_field) else $error("gain second order sign wrong");

	property p_bridge_second_order_sign_field;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) && (r_r.work[sce_pkg::OFS_BRIDGE_SOT] != 16'h0000)
			|-> coef.bridge_sot[16] == r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_BRIDGE_SECOND_ORDER_BIT];
	endproperty
	a_bridge_second_order_sign_field: assert property (p_bridge_second_order_sign_field) else $error("bridge second order sign wrong");

	property p_temp_second_order_sign_field;
		@(posedge mclk) disable iff (reset)
		(r_r.state == sce_pkg::SCE_RUN) && (r_r.work[sce_pkg::OFS_TEMP_SOT] != 16'h0000)
			|-> coef.temp_sot[16] == r_r.work[sce_pkg::OFS_SIGN_CFG][sce_pkg::SG_SOT_TEMP_BIT];
	endproperty
	a_temp_second_order_sign_field: assert property (p_temp_second_order_sign_field) else $error("temperature second order sign wrong");

endmodule // sce_word_bank

// ### shared/sce_pkg.sv
/*
 * Package for the sensor configuration word bank: word offsets, field
 * positions, factory defaults, controller states and carrier structs.
 * Assumes a single 100 MHz clock domain and 16-bit memory words.
 */
package sce_pkg;

	localparam int WORD_W = 16;
	localparam int ADDR_W = 5;
	localparam int WORDS = 32;

	// Word offsets
	localparam logic [4:0] OFS_SIGN_CFG = 5'h01;
	localparam logic [4:0] OFS_IF_CFG = 5'h02;
	localparam logic [4:0] OFS_BRIDGE_OFFSET = 5'h03;
	localparam logic [4:0] OFS_BRIDGE_GAIN = 5'h04;
	localparam logic [4:0] OFS_GAIN_TC = 5'h05;
	localparam logic [4:0] OFS_OFFSET_TC = 5'h06;
	localparam logic [4:0] OFS_OFFSET_SOT = 5'h07;
	localparam logic [4:0] OFS_GAIN_SOT = 5'h08;
	localparam logic [4:0] OFS_BRIDGE_SOT = 5'h09;
	localparam logic [4:0] OFS_TEMP_OFFSET = 5'h0A;
	localparam logic [4:0] OFS_TEMP_GAIN = 5'h0B;
	localparam logic [4:0] OFS_TEMP_SOT = 5'h0C;
	localparam logic [4:0] OFS_LOW_CAL_TEMP = 5'h0D;
	localparam logic [4:0] OFS_CUST_ID0 = 5'h00;
	localparam logic [4:0] OFS_CUSTOMER_IDENTIFIER_WORD_ONE = 5'h0E;
	localparam logic [4:0] OFS_CUST_ID2 = 5'h13;
	localparam logic [4:0] OFS_SIGNATURE = 5'h1F;
	localparam logic [4:0] OFS_LAST = 5'h1F;

	// Interface word fields
	localparam int IF_EDGE_BIT = 0;
	localparam int IF_CONN_CHK_BIT = 1;
	localparam int IF_SHORT_CHK_BIT = 2;
	localparam int IF_ADDR_LSB = 3;
	localparam int IF_COMM_LOCK_LSB = 10;
	localparam int IF_MEM_LOCK_LSB = 13;
	localparam logic [2:0] LOCK_CODE = 3'h3;

	// Sign word fields, then the gain word times-eight bit
	localparam int SG_CURVE_BIT = 9;
	localparam int SG_TC_OFFSET_BIT = 10;
	localparam int SG_TC_GAIN_BIT = 11;
	localparam int SG_BRIDGE_SECOND_ORDER_BIT = 12;
	localparam int SG_SOT_OFFSET_BIT = 13;
	localparam int SG_SOT_GAIN_BIT = 14;
	localparam int SG_SOT_TEMP_BIT = 15;
	localparam int GAIN_X8_BIT = 15;

	// Factory defaults
	localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h28;
	localparam logic [15:0] IF_CFG_DEFAULT = 16'h0140;
	localparam logic [15:0] UNITY_GAIN = 16'h2000;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	typedef enum logic [2:0] {
		SCE_LOAD = 3'b001,
		SCE_DERIVE = 3'b010,
		SCE_RUN = 3'b100
	} sce_state_t;

	typedef struct packed {
		logic miso_on_rising;
		logic conn_check_en;
		logic short_check_en;
		logic [6:0] slave_addr;
		logic comm_locked;
		logic mem_locked;
		logic curve_shape_select;
	} sce_cfg_t;

	typedef struct packed {
		logic signed [15:0] bridge_offset;
		logic [17:0] bridge_gain;
		logic signed [16:0] gain_tc;
		logic signed [16:0] offset_tc;
		logic signed [16:0] offset_sot;
		logic signed [16:0] gain_sot;
		logic signed [16:0] bridge_sot;
		logic [15:0] temp_offset;
		logic [17:0] temp_gain;
		logic signed [16:0] temp_sot;
		logic [15:0] low_cal_raw_temperature;
		logic [47:0] customer_id;
	} sce_coef_t;

	typedef struct packed {
		sce_state_t state;
		logic [4:0] idx;
		logic [31:0][15:0] work;
		sce_cfg_t cfg;
		sce_coef_t coef;
		logic diag_state;
		logic rsp_valid;
		logic [15:0] rsp_rdata;
		logic write_refused;
	} sce_regs_t;

endpackage

// ### dv/sce_host_model.sv
/*
 * Host side model: raises the enter-normal pulse on request, and at once
 * after a memory lock write when told to obey.
 * Assumes requests arrive from the bench around the falling edge.
 */
`timescale 1ns/1ps
module sce_host_model
(
	// Clock
	input wire logic mclk,
	// Observed command port
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [sce_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [sce_pkg::WORD_W-1:0] cmd_wdata,
	// Bench requests
	input wire logic nom_req,
	input wire logic obey,
	// Toward the bank
	output logic enter_normal_operation_cmd
);
	logic lock_seen_r = 1'b0;
	initial enter_normal_operation_cmd = 1'b0;
	always @(posedge mclk)
		lock_seen_r <= cmd_valid && cmd_ready && cmd_write && cmd_addr == sce_pkg::OFS_IF_CFG
			&& cmd_wdata[15:13] == sce_pkg::LOCK_CODE;
	// Obey low lets a scenario skip the signature on purpose
	always @(negedge mclk)
		enter_normal_operation_cmd <= nom_req || (obey && lock_seen_r);
endmodule // sce_host_model

// ### dv/tb_sce_word_bank.sv
/*
 * Self-checking bench for the word bank: word reads and writes, power
 * cycles, derived fields, address filter, signature and memory lock.
 * Assumes the bank starts from its factory image.
 */
`timescale 1ns/1ps
module tb_sce_word_bank;
	logic mclk = 1'b0;
	logic reset, cmd_valid, cmd_ready, cmd_write, enter_normal_operation_cmd;
	logic rsp_valid, write_refused, addr_accept, charge_pump_en, diag_state, nom_req, obey;
	logic [4:0] cmd_addr;
	logic [15:0] cmd_wdata, rsp_rdata, sum;
	logic [6:0] bus_addr;
	sce_pkg::sce_cfg_t cfg;
	sce_pkg::sce_coef_t coef;
	logic [15:0] shadow [32];
	logic [4:0] wa [16];
	logic [15:0] wd [16];
	int bad_count = 0;
	int num_checks = 0;

	always #5 mclk = ~mclk;

	sce_word_bank u_sce_word_bank (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.enter_normal_operation_cmd(enter_normal_operation_cmd), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.write_refused(write_refused), .bus_addr(bus_addr), .addr_accept(addr_accept), .cfg(cfg),
		.charge_pump_en(charge_pump_en), .diag_state(diag_state), .coef(coef));

	sce_host_model u_sce_host_model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .nom_req(nom_req), .obey(obey),
		.enter_normal_operation_cmd(enter_normal_operation_cmd));

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s exp %0h got %0h", nm, e, g);
		end
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100)
		begin
			@(negedge mclk);
			n++;
		end
		if (cmd_ready !== 1'b1)
		begin
			chk("cmd_ready", 1, cmd_ready);
			complete_run();
		end
	endtask

	// One word command; answer flags are settled at the next falling edge
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		wait_ready();
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		acc(1'b0, a, 16'h0000);
		chk("rsp_valid", 1, rsp_valid);
		chk("rsp_rdata", e, rsp_rdata);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic refused);
		acc(1'b1, a, d);
		chk("write_refused", refused, write_refused);
		if (!refused)
			shadow[a] = d;
	endtask

	// Reset stands for a power cycle of the part
	task automatic power_cycle;
		@(negedge mclk);
		reset = 1'b1;
		repeat (20) @(negedge mclk);
		reset = 1'b0;
		wait_ready();
	endtask

	initial
	begin
		reset = 1'b1;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 5'h00;
		cmd_wdata = 16'h0000;
		bus_addr = 7'h13;
		nom_req = 1'b0;
		obey = 1'b1;
		foreach (shadow[i])
			shadow[i] = 16'h0000;
		shadow[2] = 16'h0140;
		shadow[4] = 16'h2000;
		shadow[11] = 16'h2000;
		shadow[31] = 16'h4140;
		wa = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C,
			5'h0D, 5'h0E, 5'h13};
		wd = '{16'h1111, 16'hFE00, 16'h0EAF, 16'h8001, 16'h8003, 16'h0005, 16'h0006, 16'h0007, 16'h0008,
			16'h0009, 16'h0A0A, 16'h8002, 16'h000C, 16'h1234, 16'hBEEF, 16'h2222};
		power_cycle();
		for (int i = 0; i < 32; i++)
			rd(5'(i), shadow[i]);
		chk("slave_addr", 7'h28, cfg.slave_addr);
		chk("miso_edge0", 0, cfg.miso_on_rising);
		chk("bridge_gain", 18'h02000, coef.bridge_gain);
		chk("pump", 1, charge_pump_en);
		chk("accept_any", 1, addr_accept);
		for (int i = 0; i < 16; i++)
			wr(wa[i], wd[i], 1'b0);
		chk("slave_addr_early", 7'h28, cfg.slave_addr);
		rd(5'h02, 16'h0EAF);
		nom_req <= 1'b1;
		@(negedge mclk);
		nom_req <= 1'b0;
		@(negedge mclk);
		sum = 16'h0000;
		for (int i = 0; i < 31; i++)
			sum = sum + shadow[i];
		rd(5'h1F, sum);
		shadow[31] = sum;
		power_cycle();
		chk("miso_edge", 1, cfg.miso_on_rising);
		chk("conn_chk", 1, cfg.conn_check_en);
		chk("short_chk", 1, cfg.short_check_en);
		chk("slave_addr_new", 7'h55, cfg.slave_addr);
		chk("comm_locked", 1, cfg.comm_locked);
		chk("curve", 1, cfg.curve_shape_select);
		chk("bridge_offset", 16'h8001, {coef.bridge_offset});
		chk("bridge_gain_x8", 18'h00018, coef.bridge_gain);
		chk("gain_tc", 17'h1FFFB, {coef.gain_tc});
		chk("offset_tc", 17'h1FFFA, {coef.offset_tc});
		chk("offset_sot", 17'h1FFF9, {coef.offset_sot});
		chk("gain_sot", 17'h1FFF8, {coef.gain_sot});
		chk("bridge_sot", 17'h1FFF7, {coef.bridge_sot});
		chk("temp_gain", 18'h00010, coef.temp_gain);
		chk("temp_sot", 17'h1FFF4, {coef.temp_sot});
		chk("low_cal", 16'h1234, coef.low_cal_raw_temperature);
		chk("temp_offset", 16'h0A0A, coef.temp_offset);
		chk("cust_id", 48'h2222BEEF1111, coef.customer_id);
		chk("diag_ok", 0, diag_state);
		bus_addr = 7'h55;
		@(negedge mclk);
		chk("accept_own", 1, addr_accept);
		bus_addr = 7'h28;
		@(negedge mclk);
		chk("accept_other", 0, addr_accept);
		obey = 1'b0;
		wr(5'h02, 16'h6EAF, 1'b0);
		power_cycle();
		chk("mem_locked", 1, cfg.mem_locked);
		chk("pump_off", 0, charge_pump_en);
		chk("diag_bad", 1, diag_state);
		wr(5'h03, 16'h0000, 1'b1);
		rd(5'h03, 16'h8001);
		complete_run();
	end
endmodule // tb_sce_word_bank
